// *** verilog/sbaw_device.sv ***
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module sbaw_device
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    sbaw_link_if.device      link,
    input  wire logic        sleep_mode,
    output logic             baud_tick,
    output logic             receive_interrupt_flag,
    output logic             receiver_idle_flag,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic        aw_got;
    logic        w_got;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wide_divider_select;
    logic        high_speed_select;
    logic        sync_mode;
    logic        autobaud_enable;
    logic        wake_on_break_enable;
    logic        autobaud_overflow_flag;
    logic [7:0]  divisor_low_byte;
    logic [7:0]  divisor_high_byte;
    logic [5:0]  prescale;
    logic [15:0] baud_divider;
    logic        rx_prev;
    logic        abd_run;
    logic [15:0] abd_count;
    logic [2:0]  abd_rises;

    wire        rx        = link.serial_input_line;
    wire        rx_fall   = rx_prev & ~rx;
    wire        rx_rise   = ~rx_prev & rx;
    wire        wr_fire   = aw_got & w_got & ~s_axi_bvalid;
    wire        wr_ok     = aw_addr == sbaw_pkg::OFF_CTRL || aw_addr == sbaw_pkg::OFF_DIVISOR;
    wire        wr_ctrl   = wr_fire & (aw_addr == sbaw_pkg::OFF_CTRL) & w_strb[0];
    wire        wr_div_lo = wr_fire & (aw_addr == sbaw_pkg::OFF_DIVISOR) & w_strb[0];
    wire        wr_div_hi = wr_fire & (aw_addr == sbaw_pkg::OFF_DIVISOR) & w_strb[1];
    wire        rd_fire   = s_axi_arvalid & s_axi_arready;
    wire        rd_rxbuf  = rd_fire & (s_axi_araddr == sbaw_pkg::OFF_RXBUF);
    wire        rd_ok     = s_axi_araddr[1:0] == 2'h0;

    // Baud timer
    wire        wake_active = wake_on_break_enable & ~sync_mode;
    wire [15:0] divisor     = wide_divider_select
                            ? {divisor_high_byte, divisor_low_byte}
                            : {8'h00, divisor_low_byte};
    wire [5:0]  mult_last   = sync_mode ? sbaw_pkg::MULT4_LAST
                            : (high_speed_select & wide_divider_select) ? sbaw_pkg::MULT4_LAST
                            : (high_speed_select | wide_divider_select)
                            ? sbaw_pkg::MULT16_LAST
                            : sbaw_pkg::MULT64_LAST;
    // Up-count from a cleared timer, so the first tick after a divisor write is a full new period;
    // compare with >= so a smaller divisor or multiplier set mid-count cannot wrap
    wire        pre_end     = prescale >= mult_last;
    wire        timer_end   = pre_end & (baud_divider >= divisor);
    wire        div_write   = wr_div_lo | wr_div_hi;
    // Sleep holds the timer instead of clearing it, so the period resumes where it stopped
    wire [5:0]  next_prescale = div_write ? 6'h00
                              : sleep_mode ? prescale
                              : pre_end ? 6'h00
                              : prescale + 6'h01;
    wire [15:0] next_baud_divider = div_write ? 16'h0000
                                  : sleep_mode ? baud_divider
                                  : ~pre_end ? baud_divider
                                  : timer_end ? 16'h0000
                                  : baud_divider + 16'h0001;

    // Auto-baud measurement; wake mode blocks a new start but not a running count
    wire        abd_start = autobaud_enable & ~abd_run & ~wake_active & rx_fall;
    wire        abd_step  = abd_run & ~sleep_mode;
    wire        abd_done  = abd_run & rx_rise & (abd_rises == sbaw_pkg::ABD_RISES - 3'h1);
    wire        abd_ovf   = abd_step & (abd_count == 16'hFFFF);
    wire        wake_evt  = wake_active & rx_fall;
    wire        rxflag_set = abd_done | wake_evt;
    // Clear allowed only once auto-baud is already off, else flag holds
    wire        ovf_clear = wr_ctrl & ~autobaud_enable
                          & ~w_data[sbaw_pkg::BIT_OVF_FLAG];

    wire [31:0] ctrl_word = {24'h000000, receive_interrupt_flag, receiver_idle_flag,
                             autobaud_overflow_flag, wake_on_break_enable, autobaud_enable,
                             sync_mode, high_speed_select, wide_divider_select};
    wire [31:0] rd_word   = s_axi_araddr == sbaw_pkg::OFF_CTRL ? ctrl_word
                          : s_axi_araddr == sbaw_pkg::OFF_DIVISOR
                          ? {16'h0000, divisor_high_byte, divisor_low_byte}
                          : s_axi_araddr == sbaw_pkg::OFF_COUNT ? {16'h0000, abd_count}
                          : 32'h00000000;

    assign s_axi_awready      = ~aw_got & ~s_axi_bvalid;
    assign s_axi_wready       = ~w_got & ~s_axi_bvalid;
    assign s_axi_arready      = ~s_axi_rvalid;
    assign receiver_idle_flag = ~abd_run;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            aw_addr      <= 4'h0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= sbaw_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= sbaw_pkg::RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? sbaw_pkg::RESP_OKAY : sbaw_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? sbaw_pkg::RESP_OKAY : sbaw_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wide_divider_select    <= 1'b0;
            high_speed_select      <= 1'b0;
            sync_mode              <= 1'b0;
            divisor_low_byte       <= sbaw_pkg::DIVISOR_RESET[7:0];
            divisor_high_byte      <= sbaw_pkg::DIVISOR_RESET[15:8];
            prescale               <= 6'h00;
            baud_divider           <= 16'h0000;
            baud_tick              <= 1'b0;
            rx_prev                <= 1'b1;
        end
        else
        begin
            if (wr_ctrl)
            begin
                wide_divider_select <= w_data[sbaw_pkg::BIT_WIDE];
                high_speed_select   <= w_data[sbaw_pkg::BIT_HSPEED];
                sync_mode           <= w_data[sbaw_pkg::BIT_SYNC];
            end
            if (wr_div_lo)
                divisor_low_byte <= w_data[7:0];
            if (wr_div_hi)
                divisor_high_byte <= w_data[15:8];
            prescale     <= next_prescale;
            baud_divider <= next_baud_divider;
            baud_tick    <= timer_end & ~sleep_mode & ~div_write;
            rx_prev      <= rx;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            autobaud_enable        <= 1'b0;
            autobaud_overflow_flag <= 1'b0;
            wake_on_break_enable   <= 1'b0;
            receive_interrupt_flag <= 1'b0;
            abd_run                <= 1'b0;
            abd_count              <= 16'h0000;
            abd_rises              <= 3'h0;
        end
        else
        begin
            if (abd_done)
                autobaud_enable <= 1'b0;
            else if (wr_ctrl)
                autobaud_enable <= w_data[sbaw_pkg::BIT_ABAUD_EN];
            if (abd_ovf)
                autobaud_overflow_flag <= 1'b1;
            else if (ovf_clear)
                autobaud_overflow_flag <= 1'b0;
            // Hardware clear beats a software set in the same cycle
            if (wake_active && rx_rise)
                wake_on_break_enable <= 1'b0;
            else if (wr_ctrl)
                wake_on_break_enable <= w_data[sbaw_pkg::BIT_WAKE_EN];
            if (rxflag_set)
                receive_interrupt_flag <= 1'b1;
            else if (rd_rxbuf)
                receive_interrupt_flag <= 1'b0;
            if (abd_start)
            begin
                abd_run   <= 1'b1;
                abd_count <= 16'h0000;
                abd_rises <= 3'h0;
            end
            else if (abd_done || !autobaud_enable)
                abd_run <= 1'b0;
            else
            begin
                if (abd_step)
                    abd_count <= abd_count + 16'h0001;
                if (abd_run && rx_rise)
                    abd_rises <= abd_rises + 3'h1;
            end
        end
    end
endmodule // sbaw_device

// *** verilog/sbaw_pkg.sv ***
package sbaw_pkg;
    localparam logic [3:0]  OFF_CTRL       = 4'h0;
    localparam logic [3:0]  OFF_DIVISOR    = 4'h4;
    localparam logic [3:0]  OFF_RXBUF      = 4'h8;
    localparam logic [3:0]  OFF_COUNT      = 4'hC;
    localparam int          BIT_WIDE       = 0;
    localparam int          BIT_HSPEED     = 1;
    localparam int          BIT_SYNC       = 2;
    localparam int          BIT_ABAUD_EN   = 3;
    localparam int          BIT_WAKE_EN    = 4;
    localparam int          BIT_OVF_FLAG   = 5;
    localparam int          BIT_IDLE       = 6;
    localparam int          BIT_RX_FLAG    = 7;
    localparam logic [15:0] DIVISOR_RESET  = 16'h0000;
    localparam logic [5:0]  MULT64_LAST    = 6'h3F;
    localparam logic [5:0]  MULT16_LAST    = 6'h0F;
    localparam logic [5:0]  MULT4_LAST     = 6'h03;
    localparam logic [2:0]  ABD_RISES      = 3'h5;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    localparam logic [4:0]  WAKE_MIN_BITS  = 5'h0A;
    localparam logic [4:0]  WAKE_LIN_BITS  = 5'h0D;
    localparam logic [4:0]  BYTE_FRAME_BITS = 5'h0A;

    typedef enum logic [1:0]
    {
        SBAW_IDLE = 2'b01,
        SBAW_SEND = 2'b10
    } sbaw_node_state_type;
endpackage

// *** verilog/sbaw_link_if.sv ***
`timescale 1ns/1ps
interface sbaw_link_if;
    logic serial_input_line;

    modport device
    (
        input serial_input_line
    );
    modport remote
    (
        output serial_input_line
    );
endinterface

// *** verilog/sbaw_remote.sv ***
`timescale 1ns/1ps
module sbaw_remote #(
    parameter int BIT_W = 16
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    sbaw_link_if.remote           link,
    input  wire logic [BIT_W-1:0] bit_cycles,
    input  wire logic             send_start,
    input  wire logic             send_wake,
    input  wire logic [7:0]       send_byte,
    input  wire logic [4:0]       wake_bits,
    output logic                  busy
);
    sbaw_pkg::sbaw_node_state_type state;
    logic [BIT_W-1:0] cyc;
    logic [4:0]       bit_idx;
    logic [4:0]       frame_bits;
    logic [8:0]       shifter;
    logic             line;

    // Short wake requests are stretched so the far end always sees a full break
    wire [4:0] wake_len = (wake_bits < sbaw_pkg::WAKE_MIN_BITS)
                        ? sbaw_pkg::WAKE_MIN_BITS : wake_bits;
    wire       bit_end  = cyc == bit_cycles;
    wire       last_bit = bit_idx == frame_bits;
    wire       start_ok = (state == sbaw_pkg::SBAW_IDLE) & send_start;

    assign link.serial_input_line = line;
    assign busy                   = state != sbaw_pkg::SBAW_IDLE;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state      <= sbaw_pkg::SBAW_IDLE;
            cyc        <= '0;
            bit_idx    <= 5'h00;
            frame_bits <= 5'h00;
            shifter    <= 9'h000;
            line       <= 1'b1;
        end
        else
        begin
            case (state)
                sbaw_pkg::SBAW_IDLE:
                begin
                    line <= 1'b1;
                    if (start_ok)
                    begin
                        state      <= sbaw_pkg::SBAW_SEND;
                        cyc        <= '0;
                        bit_idx    <= 5'h00;
                        frame_bits <= send_wake ? wake_len : sbaw_pkg::BYTE_FRAME_BITS - 5'h01;
                        shifter    <= send_wake ? 9'h000 : {send_byte, 1'b0};
                        line       <= 1'b0;
                    end
                end
                sbaw_pkg::SBAW_SEND:
                begin
                    cyc <= bit_end ? '0 : cyc + 1'b1;
                    if (bit_end)
                    begin
                        if (last_bit)
                        begin
                            state <= sbaw_pkg::SBAW_IDLE;
                            line  <= 1'b1;
                        end
                        else
                        begin
                            bit_idx <= bit_idx + 5'h01;
                            shifter <= {1'b0, shifter[8:1]};
                            line    <= (bit_idx + 5'h01 == frame_bits) ? 1'b1 : shifter[1];
                        end
                    end
                end
                default:
                    state <= sbaw_pkg::SBAW_IDLE;
            endcase
        end
    end
endmodule // sbaw_remote

// *** verification/sbaw_link_monitor.sv ***
`timescale 1ns/1ps
module sbaw_link_monitor
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       serial_input_line,
    input wire logic       busy,
    input wire logic       baud_tick,
    input wire logic       receive_interrupt_flag,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic [3:0] s_axi_araddr,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid
);
    logic [7:0] hist;
    logic       rd_q;
    wire        rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == sbaw_pkg::OFF_RXBUF;
    // Line history lets a flag rise be traced to an edge that came a few cycles earlier
    always_ff @(posedge aclk)
    begin
        hist <= aresetn ? {hist[6:0], serial_input_line} : 8'hFF;
        rd_q <= aresetn && rd;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence tick_quiet;
        !baud_tick [*3];
    endsequence
    line_idle_a: assert property (!busy |-> serial_input_line)
        else $error("line low while remote idle");
    start_low_a: assert property ($rose(busy) |-> !serial_input_line)
        else $error("frame did not open low");
    frame_len_a: assert property ($rose(busy) |-> busy [*8])
        else $error("frame too short");
    tick_gap_a: assert property (baud_tick |=> tick_quiet)
        else $error("baud ticks closer than four cycles");
    flag_cause_a: assert property ($rose(receive_interrupt_flag) |-> hist != 8'hFF)
        else $error("receive flag rose without line edge");
    flag_hold_a: assert property (receive_interrupt_flag && !rd && !rd_q |=> receive_interrupt_flag)
        else $error("receive flag dropped without buffer read");
    flag_clear_a: assert property (rd && hist[3:0] == 4'hF && serial_input_line
        |-> ##[1:2] !receive_interrupt_flag)
        else $error("buffer read left receive flag set");
    write_answer_a: assert property (both_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
endmodule // sbaw_link_monitor

// *** verification/test_serial_baud_autobaud_wake.sv ***
`timescale 1ns/1ps
module test_serial_baud_autobaud_wake;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        sleep_mode = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid, baud_tick, busy;
    logic        receive_interrupt_flag, receiver_idle_flag;
    logic [15:0] bit_cycles = 16'h0003;
    logic        send_start = 1'b0, send_wake = 1'b0;
    logic [7:0]  send_byte = 8'h00;
    logic [4:0]  wake_bits = 5'h0D;
    int          miscompares = 0, cmp_count = 0, n;
    int          per [7] = '{192, 48, 4144, 1036, 12, 12, 1036};
    logic [31:0] cfg [7] = '{32'h0, 32'h2, 32'h1, 32'h3, 32'h4, 32'h6, 32'h5};
    sbaw_link_if link_if ();
    always #10 aclk = ~aclk;
    sbaw_device u_sbaw_device
    (
        .aclk(aclk), .aresetn(aresetn), .link(link_if), .sleep_mode(sleep_mode),
        .baud_tick(baud_tick), .receive_interrupt_flag(receive_interrupt_flag),
        .receiver_idle_flag(receiver_idle_flag), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    sbaw_remote u_sbaw_remote
    (
        .aclk(aclk), .aresetn(aresetn), .link(link_if), .bit_cycles(bit_cycles),
        .send_start(send_start), .send_wake(send_wake), .send_byte(send_byte),
        .wake_bits(wake_bits), .busy(busy)
    );
    sbaw_link_monitor mon
    (
        .aclk(aclk), .aresetn(aresetn), .serial_input_line(link_if.serial_input_line),
        .busy(busy), .baud_tick(baud_tick), .receive_interrupt_flag(receive_interrupt_flag),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bvalid(bvalid), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rvalid(rvalid)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("counts: %0d compared, %0d unexpected", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok || awready === 1'b1;
            w_ok = w_ok || wready === 1'b1;
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Counts the first low span of the frame, the part a wake or rate measurement sees
    task automatic send(input logic wk, input logic [7:0] b, input logic [15:0] bc);
        @(posedge aclk);
        send_wake <= wk;
        send_byte <= b;
        bit_cycles <= bc;
        send_start <= 1'b1;
        @(posedge aclk);
        send_start <= 1'b0;
        n = 0;
        while (link_if.serial_input_line !== 1'b0) @(posedge aclk);
        while (link_if.serial_input_line === 1'b0)
        begin
            n++;
            @(posedge aclk);
        end
        while (busy === 1'b1) @(posedge aclk);
        @(posedge aclk);
    endtask
    task automatic gap(input int s);
        do @(posedge aclk); while (baud_tick !== 1'b1);
        n = s;
        if (s > 0)
        begin
            sleep_mode <= 1'b1;
            repeat (s) @(posedge aclk);
            sleep_mode <= 1'b0;
        end
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (baud_tick !== 1'b1);
    endtask
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(sbaw_pkg::OFF_CTRL);
        chk(d, 32'h40);
        rd(sbaw_pkg::OFF_DIVISOR);
        chk(d, 32'h0);
        rd(4'h2);
        chk(32'(r), 32'(sbaw_pkg::RESP_SLVERR));
        wr(sbaw_pkg::OFF_RXBUF, 32'h0);
        chk(32'(r), 32'(sbaw_pkg::RESP_SLVERR));
        $display("test reset done");
        wr(sbaw_pkg::OFF_DIVISOR, 32'hFFFF);
        repeat (100) @(posedge aclk);
        wr(sbaw_pkg::OFF_DIVISOR, 32'h0102);
        n = 0;
        while (baud_tick !== 1'b1)
        begin
            @(posedge aclk);
            n++;
        end
        chk(32'(n >= 188 && n <= 196), 32'h1);
        // Divisor rewritten after each mode change so the timer restarts from a cleared count
        for (int i = 0; i < 7; i++)
        begin
            wr(sbaw_pkg::OFF_CTRL, cfg[i]);
            wr(sbaw_pkg::OFF_DIVISOR, 32'h0102);
            gap(0);
            chk(32'(n), 32'(per[i]));
        end
        wr(sbaw_pkg::OFF_CTRL, 32'h4);
        wr(sbaw_pkg::OFF_DIVISOR, 32'h0102);
        gap(50);
        chk(32'(n), 32'd62);
        $display("test baud done");
        wr(sbaw_pkg::OFF_CTRL, 32'h0);
        chk(32'(receiver_idle_flag), 32'h1);
        wr(sbaw_pkg::OFF_CTRL, 32'h10);
        sleep_mode <= 1'b1;
        send(1'b1, 8'h00, 16'h0003);
        sleep_mode <= 1'b0;
        chk(32'(n), 32'd52);
        chk(32'(receive_interrupt_flag), 32'h1);
        rd(sbaw_pkg::OFF_CTRL);
        chk(d, 32'hC0);
        rd(sbaw_pkg::OFF_RXBUF);
        rd(sbaw_pkg::OFF_CTRL);
        chk(d, 32'h40);
        wr(sbaw_pkg::OFF_CTRL, 32'h10);
        send(1'b0, 8'hF0, 16'h0003);
        chk(32'(n), 32'd20);
        rd(sbaw_pkg::OFF_CTRL);
        chk(d, 32'hC0);
        rd(sbaw_pkg::OFF_RXBUF);
        wr(sbaw_pkg::OFF_CTRL, 32'h14);
        send(1'b0, 8'h00, 16'h0003);
        chk(32'(receive_interrupt_flag), 32'h0);
        $display("test wake done");
        wr(sbaw_pkg::OFF_CTRL, 32'h8);
        send(1'b0, 8'h55, 16'h0003);
        rd(sbaw_pkg::OFF_CTRL);
        chk(d, 32'hC0);
        rd(sbaw_pkg::OFF_RXBUF);
        wr(sbaw_pkg::OFF_CTRL, 32'h8);
        send(1'b0, 8'h55, 16'h1C83);
        rd(sbaw_pkg::OFF_CTRL);
        chk(d, 32'hE0);
        rd(sbaw_pkg::OFF_RXBUF);
        wr(sbaw_pkg::OFF_CTRL, 32'h28);
        wr(sbaw_pkg::OFF_CTRL, 32'h8);
        rd(sbaw_pkg::OFF_CTRL);
        chk(d & 32'h28, 32'h28);
        wr(sbaw_pkg::OFF_CTRL, 32'h20);
        rd(sbaw_pkg::OFF_CTRL);
        chk(d & 32'h28, 32'h20);
        wr(sbaw_pkg::OFF_CTRL, 32'h0);
        rd(sbaw_pkg::OFF_CTRL);
        chk(d & 32'h20, 32'h0);
        $display("test autobaud done");
        end_sim();
    end
    initial
    begin
        repeat (95000) @(posedge aclk);
        miscompares++;
        end_sim();
    end
endmodule // test_serial_baud_autobaud_wake
